// *** bench/slc_clock_partner.sv ***
// Model of the clock controller beside the sleep controller.
// Assumes run enables come from the controller on the same clock.
`timescale 1ns/1ps

module slc_clock_partner #(
    parameter int OSC_START = 4,
    parameter int BOD_DELAY = 24
) (
    // Clock and run requests.
    aclk,
    clk_run,
    // Readiness levels.
    main_clk_ready,
    bod_ready
);
    input  wire logic                 aclk;
    input  wire slc_pkg::slc_clk_type clk_run;
    output logic                      main_clk_ready;
    output logic                      bod_ready;

    int osc_cnt = 0;
    int bod_cnt = 0;

    ////////////////////////////////////////
    // oscillator start-up
    // A stopped source is never ready at once, so wakes see the delay.
    always @(posedge aclk) begin
        if (!clk_run.main_osc)
            osc_cnt <= 0;
        else if (osc_cnt < OSC_START)
            osc_cnt <= osc_cnt + 1;
    end

    // brownout readiness lag
    // The detector settles only after the main source has stabilised.
    always @(posedge aclk) begin
        if (!main_clk_ready)
            bod_cnt <= 0;
        else if (bod_cnt < BOD_DELAY)
            bod_cnt <= bod_cnt + 1;
    end

    assign main_clk_ready = (osc_cnt == OSC_START);
    assign bod_ready      = (bod_cnt == BOD_DELAY);
endmodule

// *** bench/testbench.sv ***
// Self-checking bench of the sleep controller and its clock partner.
// Assumes the package and design files are compiled before it.
`timescale 1ns/1ps

module testbench;
    localparam int OSC = 4;
    localparam int BROWNOUT_DETECTOR = 24;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, bod_active_fuse;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        sleep_instr, debug_break, cpu_halt, wake_pulse;
    logic        main_osc_needed, rtc_osc_needed, ulp_needed;
    logic        main_clk_ready, bod_ready, ultra_low_power_osc_run;
    slc_pkg::slc_wake_type wake_req;
    slc_pkg::slc_stby_type run_in_standby;
    slc_pkg::slc_clk_type  clk_run;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    slc_sleep_ctrl slc_sleep_ctrl_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .sleep_instr, .debug_break,
        .cpu_halt, .wake_pulse, .wake_req, .run_in_standby,
        .main_osc_needed, .rtc_osc_needed, .ulp_needed, .main_clk_ready,
        .bod_active_fuse, .bod_ready, .clk_run, .ultra_low_power_osc_run
    );
    slc_clock_partner #(.OSC_START(OSC), .BOD_DELAY(BROWNOUT_DETECTOR))
        slc_clock_partner_inst (.aclk, .clk_run, .main_clk_ready,
                                .bod_ready);

    ////////////////////////////////////////
    // Clock, and a cycle ceiling so that a hang still ends the run.
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Write: address and data offered together, each dropped when taken.
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // One-cycle sleep instruction, then time for the gating to settle.
    task automatic pulse_sleep();
        @(posedge aclk);
        sleep_instr <= 1'b1;
        @(posedge aclk);
        sleep_instr <= 1'b0;
        repeat (3) @(posedge aclk);
        #1;
    endtask

    // Edges counted from the one that first sees the wake cause.
    task automatic wait_wake(output int n);
        n = 0;
        do begin
            @(posedge aclk);
            #1;
            n++;
        end while (wake_pulse !== 1'b1 && n < 90);
    endtask

    // Source index 0 is the pin request, 7 the catch-all request.
    function automatic bit wakes(logic [1:0] m, int i,
                                 slc_pkg::slc_stby_type s);
        case (m)
            2'h0: return 1'b1;
            2'h1: return i < 3 || i == 6 || (i == 3 && s.usart) ||
                         (i == 4 && s.adc) || (i == 5 && s.rtc);
            default: return i < 2;
        endcase
    endfunction

    function automatic logic [7:0] exp_clk(logic [1:0] m,
                                           slc_pkg::slc_stby_type s,
                                           logic mn, logic rn);
        case (m)
            2'h0: return 8'h7f;
            2'h1: return {2'h0, s.rtc, s.adc, 2'h3, mn, rn};
            default: return 8'h0c;
        endcase
    endfunction

    ////////////////////////////////////////
    // Main sequence: map, refused sleeps, every mode and source, reset.
    initial begin
        logic [31:0] d, q;
        logic [1:0]  r, m;
        int          n, b;
        bit          keep;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        {sleep_instr, debug_break, wake_req, run_in_standby} = '0;
        {main_osc_needed, rtc_osc_needed, ulp_needed} = '0;
        s_axi_wstrb = 4'hf;
        bod_active_fuse = 2'h0;
        aresetn = 1'b0;
        void'($urandom(85));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axr(8'h00, q, r);
        check("ctrl reset", q, 32'h0);
        axr(8'h08, q, r);
        check("unmapped resp", r, 2'h2);
        axw(8'h08, 32'h7, r);
        check("unmapped wr resp", r, 2'h2);
        axw(8'h00, 32'h4, r);
        pulse_sleep();
        check("halt no enable", cpu_halt, 1'b0);
        axw(8'h00, 32'h7, r);
        pulse_sleep();
        check("halt reserved", cpu_halt, 1'b0);
        for (int i = 0; i < 24; i++) begin
            m = 2'(i / 8);
            b = i % 8;
            d = $urandom;
            d[2:0] = {m, 1'b1};
            @(posedge aclk);
            run_in_standby <= slc_pkg::slc_stby_type'(3'($urandom));
            {main_osc_needed, rtc_osc_needed} <= 2'($urandom);
            ulp_needed <= 1'($urandom);
            bod_active_fuse <= 2'($urandom);
            axw(8'h00, d, r);
            check("write resp", r, 2'h0);
            axr(8'h00, q, r);
            check("ctrl read", q, {29'h0, d[2:0]});
            pulse_sleep();
            check("halt", cpu_halt, 1'b1);
            check("gated clocks", clk_run & (m == 2'h2 ? 8'hfe : 8'hff),
                  exp_clk(m, run_in_standby, main_osc_needed,
                          rtc_osc_needed));
            check("ulp osc", ultra_low_power_osc_run,
                  m == 2'h2 ? ulp_needed : 1'b1);
            if (m == 2'h2)
                check("rtc osc", clk_run.rtc_osc, ulp_needed);
            axr(8'h04, q, r);
            check("status asleep", q, {28'h0, m, 2'h1});
            @(posedge aclk);
            wake_req <= slc_pkg::slc_wake_type'(8'h80 >> b);
            if (!wakes(m, b, run_in_standby)) begin
                repeat (4) @(posedge aclk);
                #1;
                check("ignored wake", cpu_halt, 1'b1);
                @(posedge aclk);
                wake_req <= '0;
                debug_break <= 1'b1;
            end
            wait_wake(n);
            check("halt after wake", cpu_halt, 1'b0);
            keep = m == 2'h0 || (m == 2'h1 && main_osc_needed);
            if (keep)
                check("quick wake", 32'(n), 32'h8);
            else if (bod_active_fuse == 2'h3)
                check("bod wait", n >= OSC + BROWNOUT_DETECTOR, 1'b1);
            else
                check("osc wake", n >= 8 && n < OSC + BROWNOUT_DETECTOR, 1'b1);
            @(posedge aclk);
            #1;
            check("pulse width", wake_pulse, 1'b0);
            @(posedge aclk);
            wake_req <= '0;
            debug_break <= 1'b0;
            repeat (40) @(posedge aclk);
            #1;
            check("clocks active", clk_run, 8'hff);
        end
        axw(8'h00, 32'h5, r);
        pulse_sleep();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
        check("halt in reset", cpu_halt, 1'b0);
        check("clocks in reset", clk_run, 8'hff);
        @(posedge aclk);
        aresetn <= 1'b1;
        axr(8'h00, q, r);
        check("ctrl after reset", q, 32'h0);
        conclude();
    end
endmodule

// *** logic/slc_pkg.sv ***
// Types of the sleep controller.
// Assumes the constants header is included by the modules that need it.
package slc_pkg;
    // Sleep state of the controller.
    typedef enum logic [1:0] {
        SLC_ACTIVE,
        SLC_ASLEEP,
        SLC_WAKING
    } slc_state_type;

    // Standby permissions for gated peripherals.
    typedef struct packed {
        logic rtc;
        logic adc;
        logic usart;
    } slc_stby_type;

    // Wake request lines from interrupt sources.
    typedef struct packed {
        logic pin;
        logic addr_match;
        logic capture_timer;
        logic usart_sof;
        logic adc_window;
        logic rtc;
        logic periodic;
        logic other;
    } slc_wake_type;

    // Clock domain and oscillator run requests.
    typedef struct packed {
        logic cpu_clk;
        logic per_clk;
        logic rtc_clk;
        logic adc_clk;
        logic periodic_clk;
        logic wdt_clk;
        logic main_osc;
        logic rtc_osc;
    } slc_clk_type;
endpackage

// *** logic/slc_regs.svh ***
// Constants of the sleep controller: register map, fields, reset values,
// and wake-up timing.
// Assumes a 32-bit AXI4-Lite register bus and a 10 MHz peripheral clock.
// How it works
// - Sleep only on sleep instruction with enable set
// - Mode codes: idle, standby, power down, reserved
// - Idle halts CPU, peripherals keep clocks
// - Idle wakes on any enabled interrupt
// - Standby clocks only run-in-standby peripherals
// - Standby wake sources, some gated by standby bits
// - Standby oscillators run only when needed; ultra_low_power_osc_run stays high throughout standby
// - Power down keeps watchdog and periodic timer
// - Power down wakes on pin or address match
// - Resume six clocks after main clock ready
// - Idle keeps main oscillator running
// - Power down keeps only low-power and counter clocks
// - Brownout fuse three extends wake until ready
// - Debug break wakes the device
// - Running debug leaves operation normal
// - Control register layout and zero reset
// - Controller runs on the peripheral clock
// - Interrupt routine runs, then next instruction
// - Any reset ends sleep
`ifndef SLC_REGS_SVH
`define SLC_REGS_SVH

`define SLC_CTRL_OFFSET   8'h00
`define SLC_STAT_OFFSET   8'h04
`define SLC_CTRL_RESET    8'h00
`define SLC_SEN_BIT       0
`define SLC_MODE_LSB      1
`define SLC_MODE_MSB      2
`define SLC_MODE_IDLE     2'h0
`define SLC_MODE_STANDBY  2'h1
`define SLC_MODE_POWER_DOWN_CODE    2'h2
`define SLC_BOD_WAIT_CODE 2'h3
`define SLC_WAKE_CYCLES   4'h6
`define SLC_RESP_OKAY     2'h0
`define SLC_RESP_SLVERR   2'h2

`endif

// *** logic/slc_sleep_ctrl.sv ***
// Sleep controller: mode register, sleep state and clock gating.
// Assumes the CPU pulses sleep_instr and a 10 MHz peripheral clock.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "slc_regs.svh"

module slc_sleep_ctrl (
    // Clock and reset.
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // AXI4-Lite write channels.
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read channels.
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // CPU and debug.
    input  wire logic                 sleep_instr,
    input  wire logic                 debug_break,
    output logic                      cpu_halt,
    output logic                      wake_pulse,
    // Wake sources and peripheral configuration.
    input  wire slc_pkg::slc_wake_type wake_req,
    input  wire slc_pkg::slc_stby_type run_in_standby,
    input  wire logic                 main_osc_needed,
    input  wire logic                 rtc_osc_needed,
    input  wire logic                 ulp_needed,
    // Clock controller.
    input  wire logic                 main_clk_ready,
    input  wire logic [1:0]           bod_active_fuse,
    input  wire logic                 bod_ready,
    output slc_pkg::slc_clk_type      clk_run,
    output logic                      ultra_low_power_osc_run
);
    slc_pkg::slc_state_type state_reg;
    slc_pkg::slc_state_type state_next;
    logic [7:0]  ctrl_reg;
    logic [1:0]  mode_reg;
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic        w_strb_reg;
    logic        timer_done;
    slc_pkg::slc_clk_type clk_next;
    logic        ulp_next;

    ////////////////////////////////////////////////////////////////////
    // Decoding shared by the write and read paths.
    function automatic logic slc_mapped(input logic [7:0] addr);
        slc_mapped = (addr == `SLC_CTRL_OFFSET) ||
                     (addr == `SLC_STAT_OFFSET);
    endfunction

    // Write address and data are taken separately, in either order.
    wire aw_take   = s_axi_awvalid && s_axi_awready;
    wire w_take    = s_axi_wvalid && s_axi_wready;
    wire wr_fire   = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire wr_ctrl   = wr_fire && (aw_addr_reg == `SLC_CTRL_OFFSET)
                     && w_strb_reg;
    wire ar_take   = s_axi_arvalid && s_axi_arready;
    wire [1:0] sel_mode = ctrl_reg[`SLC_MODE_MSB:`SLC_MODE_LSB];
    wire sleep_enable_bit       = ctrl_reg[`SLC_SEN_BIT];
    wire mode_ok   = (sel_mode != 2'h3);

    ////////////////////////////////////////////////////////////////////
    // Write channel handshake.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SLC_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_reg   <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_held_reg   <= 1'b1;
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= slc_mapped(aw_addr_reg) ?
                                `SLC_RESP_OKAY : `SLC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control register; the upper five bits are never stored.
    // control register layout
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `SLC_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= {5'h00, w_data_reg[2:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read channel; status shows the sleep state and mode in effect.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `SLC_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= slc_mapped(s_axi_araddr) ?
                             `SLC_RESP_OKAY : `SLC_RESP_SLVERR;
            if (s_axi_araddr == `SLC_CTRL_OFFSET)
                s_axi_rdata <= {24'h00_0000, ctrl_reg};
            else if (s_axi_araddr == `SLC_STAT_OFFSET)
                s_axi_rdata <= {28'h000_0000, mode_reg, state_reg};
            else
                s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Wake qualification by the mode latched at sleep entry. Debug
    // without a break never enters here, so it changes nothing.
    // no break, no effect
    wire wake_idle  = |wake_req;
    wire wake_stby  = wake_req.pin || wake_req.addr_match ||
                      wake_req.capture_timer || wake_req.periodic ||
                      (wake_req.usart_sof && run_in_standby.usart) ||
                      (wake_req.adc_window && run_in_standby.adc) ||
                      (wake_req.rtc && run_in_standby.rtc);
    wire wake_power_down_code = wake_req.pin || wake_req.addr_match;
    wire wake_mode  = (mode_reg == `SLC_MODE_IDLE)    ? wake_idle :
                      (mode_reg == `SLC_MODE_STANDBY) ? wake_stby :
                      wake_power_down_code;
    wire wake_now   = wake_mode || debug_break;
    wire enter      = sleep_instr && sleep_enable_bit && mode_ok;

    // Sleep state sequence.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            slc_pkg::SLC_ACTIVE: if (enter) state_next = slc_pkg::SLC_ASLEEP;
            slc_pkg::SLC_ASLEEP:
                if (wake_now) state_next = slc_pkg::SLC_WAKING;
            slc_pkg::SLC_WAKING:
                if (timer_done) state_next = slc_pkg::SLC_ACTIVE;
            default:             state_next = slc_pkg::SLC_ACTIVE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= slc_pkg::SLC_ACTIVE;
            mode_reg  <= `SLC_MODE_IDLE;
        end else begin
            state_reg <= state_next;
            if (enter && state_reg == slc_pkg::SLC_ACTIVE)
                mode_reg <= sel_mode;
        end
    end

    slc_wake_timer u_timer (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .start      (state_reg == slc_pkg::SLC_ASLEEP && wake_now),
        .main_ready (main_clk_ready),
        .bod_wait   (bod_active_fuse == `SLC_BOD_WAIT_CODE),
        .bod_ready  (bod_ready),
        .done       (timer_done)
    );

    ////////////////////////////////////////////////////////////////////
    // Clock requests while asleep; waking raises every clock but the CPU clock at once.
    wire sleeping = (state_reg == slc_pkg::SLC_ASLEEP);
    wire is_idle  = mode_reg == `SLC_MODE_IDLE;
    wire is_stby  = mode_reg == `SLC_MODE_STANDBY;
    always_comb begin
        clk_next = '1;
        ulp_next = 1'b1;
        if (state_reg != slc_pkg::SLC_ACTIVE) begin
            clk_next.cpu_clk = 1'b0;
        end
        if (sleeping && !is_idle) begin
            clk_next.per_clk = 1'b0;
            clk_next.rtc_clk = is_stby && run_in_standby.rtc;
            clk_next.adc_clk = is_stby && run_in_standby.adc;
            clk_next.main_osc = is_stby && main_osc_needed;
            clk_next.rtc_osc  = is_stby ? rtc_osc_needed : ulp_needed;
            ulp_next          = is_stby || ulp_needed;
            clk_next.periodic_clk = 1'b1;
            clk_next.wdt_clk      = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_run                 <= '1;
            ultra_low_power_osc_run <= 1'b1;
            cpu_halt                <= 1'b0;
            wake_pulse              <= 1'b0;
        end else begin
            clk_run                 <= clk_next;
            ultra_low_power_osc_run <= ulp_next;
            cpu_halt                <= state_next != slc_pkg::SLC_ACTIVE;
            wake_pulse <= state_reg == slc_pkg::SLC_WAKING && timer_done;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks on the sleep sequence and the clock requests.
    // The wake edge, six counts and the registered return to active
    // make eight edges when the main source is already running.
    // wake delay bound
    wake_delay_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        state_reg == slc_pkg::SLC_ASLEEP && wake_now && main_clk_ready &&
        bod_active_fuse != `SLC_BOD_WAIT_CODE
        |-> ##8 state_reg == slc_pkg::SLC_ACTIVE)
        else $error("Wake took other than the fixed count.");
    no_sleep_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        state_reg == slc_pkg::SLC_ACTIVE && !sleep_enable_bit |=> !cpu_halt)
        else $error("Sleep entered without enable.");
    reserved_mode_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        state_reg == slc_pkg::SLC_ACTIVE && sel_mode == 2'h3 |=> !cpu_halt)
        else $error("Sleep entered with the reserved mode.");
    power_down_code_wake_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        sleeping && mode_reg == `SLC_MODE_POWER_DOWN_CODE && !wake_req.pin &&
        !wake_req.addr_match && !debug_break
        |=> state_reg != slc_pkg::SLC_WAKING)
        else $error("Power down woke on a masked source.");
    stby_wake_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        sleeping && is_stby && wake_req.capture_timer
        |=> state_reg == slc_pkg::SLC_WAKING)
        else $error("Standby ignored the capture timer.");
    debug_wake_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        sleeping && debug_break |=> state_reg == slc_pkg::SLC_WAKING)
        else $error("Debug break did not wake.");
    idle_clock_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        sleeping && is_idle |=> clk_run.per_clk && !clk_run.cpu_clk)
        else $error("Idle clocks wrong.");
    idle_osc_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        sleeping && is_idle |=> clk_run.main_osc)
        else $error("Idle stopped the main source.");
    power_down_code_clocks_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        sleeping && mode_reg == `SLC_MODE_POWER_DOWN_CODE |=> clk_run.wdt_clk &&
        clk_run.periodic_clk && !clk_run.per_clk && !clk_run.main_osc)
        else $error("Power down clocks wrong.");
    pulse_width_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wake_pulse |=> !wake_pulse)
        else $error("Resume pulse longer than one cycle.");
endmodule

// *** logic/slc_wake_timer.sv ***
// Wake-up delay counter of the sleep controller.
// Assumes start is a one-cycle pulse; clock ready inputs are levels.
`timescale 1ns/1ps
`include "slc_regs.svh"

module slc_wake_timer #(
    parameter logic [3:0] WAKE_CYCLES = `SLC_WAKE_CYCLES
) (
    // Clock and reset.
    input  wire logic aclk,
    input  wire logic aresetn,
    // Control.
    input  wire logic start,
    input  wire logic main_ready,
    input  wire logic bod_wait,
    input  wire logic bod_ready,
    output logic      done
);
    logic [3:0] count_reg;
    logic       busy_reg;
    wire        count_end = (count_reg == WAKE_CYCLES);
    wire        bod_ok    = !bod_wait || bod_ready;

    ////////////////////////////////////////////////////////////////////
    // Counting starts only once the main clock is available, so the
    // oscillator start-up simply adds in front of the fixed count.
    // six cycles after clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= 4'h0;
            busy_reg  <= 1'b0;
        end else if (start) begin
            count_reg <= 4'h0;
            busy_reg  <= 1'b1;
        end else if (busy_reg && main_ready && !count_end) begin
            count_reg <= count_reg + 4'h1;
        end else if (done) begin
            busy_reg  <= 1'b0;
        end
    end

    assign done = busy_reg && count_end && bod_ok;
endmodule
